// file: src/cpuit_decoder.sv
// Instruction decoder that classifies and times each instruction
// Overview of operation
// RULE_01: Decode all compact 16-bit instructions except the three excluded ones.
// RULE_02: Accept only branch-with-link, three barriers, special register read/write as wide.
// RULE_03: Every count below assumes memory with no wait states.
// RULE_04: Immediate and register shifts and rotate complete in one cycle.
// RULE_05: Byte and halfword sign or zero extension takes one cycle.
// RULE_06: The three byte reversal operations take one cycle each.
// RULE_07: Stack pointer adjust and address forming from SP or PC take one cycle.
// RULE_08: Single loads and stores take two cycles, or one to the I/O port.
// RULE_09: Load/store multiple, plain push and pop take one plus N cycles.
// RULE_10: Push with link takes 1+N, pop with PC takes 3+N.
// RULE_11: Conditional branch takes two cycles taken, one not taken.
// RULE_12: Register branch with exchange, linked or not, takes two cycles.
// RULE_13: Event and interrupt waits take two cycles, yield one, excluding sleep.
// RULE_14: Supervisor call and breakpoint timing follows configuration parameters.
// RULE_15: PC-destination moves/adds and plain branch 2, link branch, system ops 3.
// RULE_16: Excluded encodings are reported undefined, never executed.
`timescale 1ns/1ns
`include "cpuit_params.svh"

module cpuit_decoder #(
  parameter logic [4:0] SUPCALL_CYCLES = 5'h04,
  parameter logic [4:0] BREAK_CYCLES = 5'h04
) (
  // Clock, reset and enable
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // Instruction request
  input wire logic instValid,
  input wire logic [15:0] instLo,
  input wire logic [15:0] instHi,
  input wire logic ioTarget,
  input wire logic condTaken,
  // Execution status
  output logic instReady,
  output logic instDone,
  output cpuit_pkg::cpuit_dec_t decInfo
);

  if (SUPCALL_CYCLES == 5'h00 || BREAK_CYCLES == 5'h00) begin
    $error("trap cycle counts must be at least one");
  end

  logic rstMeta_ff;
  logic rstSyncN_ff;
  cpuit_pkg::cpuit_state_t state_ff;
  cpuit_pkg::cpuit_state_t nxt_state;
  logic [4:0] cnt_ff;
  logic [4:0] nxt_cnt;
  logic ready_ff;
  logic nxt_ready;
  logic done_ff;
  logic nxt_done;
  cpuit_pkg::cpuit_dec_t info_ff;
  cpuit_pkg::cpuit_dec_t nxt_info;
  cpuit_pkg::cpuit_dec_t dec;
  logic [4:0] nReg;
  logic [4:0] memCyc;
  logic accept;

  // Reset release through two flip-flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rstMeta_ff <= 1'b0;
      rstSyncN_ff <= 1'b0;
    end else begin
      rstMeta_ff <= 1'b1;
      rstSyncN_ff <= rstMeta_ff;
    end
  end

  assign accept = ce && instValid && ready_ff;

  // Classification and cycle count of the presented instruction
  always_comb begin
    dec.cls = cpuit_pkg::CL_ALU;
    dec.cycles = `CPUIT_CYC_1;
    dec.undef = 1'b0;
    dec.wide = 1'b0;
    nReg = 5'($countones(instLo[7:0]));
    // RULE_08 single access latency by target
    memCyc = ioTarget ? `CPUIT_CYC_1 : `CPUIT_CYC_2;
    if (instLo[15:11] == `CPUIT_W32_A || instLo[15:11] == `CPUIT_W32_B ||
        instLo[15:11] == `CPUIT_W32_C) begin
      dec.wide = 1'b1;
      dec.cls = cpuit_pkg::CL_SYS;
      dec.cycles = `CPUIT_CYC_3;
      // RULE_02 wide encoding filter
      if (instLo[15:11] == `CPUIT_W32_B &&
          instHi[15:14] == `CPUIT_BLINK_HI &&
          instHi[12]) begin
        // RULE_15 linked branch timing
        dec.cls = cpuit_pkg::CL_BRANCH;
      end else if (instLo == `CPUIT_BAR_LO &&
                   instHi[15:8] == `CPUIT_BAR_HI &&
                   instHi[7:4] >= `CPUIT_BAR_MIN &&
                   instHi[7:4] <= `CPUIT_BAR_MAX) begin
        dec.cls = cpuit_pkg::CL_SYS;
      end else if ((instLo[15:4] == `CPUIT_SPECRD_LO ||
                    instLo[15:4] == `CPUIT_SPECWR_LO) &&
                   instHi[15:14] == `CPUIT_SPEC_HI) begin
        dec.cls = cpuit_pkg::CL_SYS;
      end else begin
        dec.cls = cpuit_pkg::CL_UNDEF;
        dec.cycles = `CPUIT_CYC_1;
        dec.undef = 1'b1;
      end
    end else if (instLo[15:10] == `CPUIT_OP6_HIREG) begin
      if (instLo[9:8] == `CPUIT_HIREG_BRX) begin
        // RULE_12 register branch with exchange
        dec.cls = cpuit_pkg::CL_BRANCH;
        dec.cycles = `CPUIT_CYC_2;
      end else if (instLo[9:8] != `CPUIT_HIREG_CMP &&
                   {instLo[7], instLo[2:0]} == `CPUIT_REG_PC) begin
        // RULE_15 move or add into PC
        dec.cls = cpuit_pkg::CL_BRANCH;
        dec.cycles = `CPUIT_CYC_2;
      end
    end else if (instLo[15:11] == `CPUIT_OP5_LIT ||
                 instLo[15:12] == `CPUIT_OP4_LSREG ||
                 instLo[15:13] == `CPUIT_OP3_LSIMM ||
                 instLo[15:12] == `CPUIT_OP4_LSH ||
                 instLo[15:12] == `CPUIT_OP4_LSSP) begin
      // RULE_08 single load or store
      dec.cls = cpuit_pkg::CL_MEM;
      dec.cycles = memCyc;
    end else if (instLo[15:12] == `CPUIT_OP4_MULTI) begin
      // RULE_09 load or store multiple
      dec.cls = cpuit_pkg::CL_MULTI;
      dec.cycles = `CPUIT_MULTI_BASE + nReg;
    end else if (instLo[15:12] == `CPUIT_OP4_MISC) begin
      if (!instLo[10] && instLo[8]) begin
        // RULE_16 compare and branch treated as undefined
        dec.cls = cpuit_pkg::CL_UNDEF;
        dec.undef = 1'b1;
      end else if (instLo[11:8] == `CPUIT_MISC_HINT) begin
        if (instLo[3:0] != 4'h0) begin
          // RULE_16 conditional block treated as undefined
          dec.cls = cpuit_pkg::CL_UNDEF;
          dec.undef = 1'b1;
        end else begin
          // RULE_13 hint timing, other codes run as no-op
          dec.cls = cpuit_pkg::CL_HINT;
          if (instLo[7:4] == `CPUIT_HINT_EVWAIT ||
              instLo[7:4] == `CPUIT_HINT_IRQWAIT) begin
            dec.cycles = `CPUIT_CYC_2;
          end
        end
      end else if (instLo[10:9] == `CPUIT_PUSHPOP) begin
        dec.cls = cpuit_pkg::CL_MULTI;
        // RULE_10 link register or PC counted in the list
        if (instLo[11] && instLo[8]) begin
          dec.cycles = `CPUIT_POPPC_BASE + nReg + 5'h01;
        end else begin
          // RULE_09 plain push or pop, RULE_10 push with link register
          dec.cycles = `CPUIT_MULTI_BASE + nReg + {4'h0, instLo[8]};
        end
      end else if (instLo[11:8] == `CPUIT_MISC_BREAK) begin
        // RULE_14 breakpoint timing by configuration
        dec.cls = cpuit_pkg::CL_TRAP;
        dec.cycles = BREAK_CYCLES;
      end else if (instLo[11:8] == `CPUIT_MISC_SP ||
                   instLo[11:8] == `CPUIT_MISC_EXT ||
                   instLo[11:5] == `CPUIT_MISC_CPS) begin
        // RULE_05 extension, RULE_07 stack pointer adjust
        dec.cls = cpuit_pkg::CL_ALU;
      end else if (instLo[11:8] == `CPUIT_MISC_REV &&
                   instLo[7:6] != `CPUIT_REV_BAD) begin
        // RULE_06 byte reversal
        dec.cls = cpuit_pkg::CL_ALU;
      end else begin
        dec.cls = cpuit_pkg::CL_UNDEF;
        dec.undef = 1'b1;
      end
    end else if (instLo[15:12] == `CPUIT_OP4_COND) begin
      if (instLo[11:8] == `CPUIT_COND_SUPCALL) begin
        // RULE_14 supervisor call timing by configuration
        dec.cls = cpuit_pkg::CL_TRAP;
        dec.cycles = SUPCALL_CYCLES;
      end else if (instLo[11:8] == `CPUIT_COND_UDF) begin
        dec.cls = cpuit_pkg::CL_UNDEF;
        dec.undef = 1'b1;
      end else begin
        // RULE_11 conditional branch
        dec.cls = cpuit_pkg::CL_BRANCH;
        dec.cycles = condTaken ? `CPUIT_CYC_2 : `CPUIT_CYC_1;
      end
    end else if (instLo[15:11] == `CPUIT_OP5_BRU) begin
      // RULE_15 unconditional branch
      dec.cls = cpuit_pkg::CL_BRANCH;
      dec.cycles = `CPUIT_CYC_2;
    end
    // RULE_01 remaining compact forms, RULE_04 shifts, RULE_07 address
  end

  // Execution sequencer: one instruction per counted slot
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_ready = ready_ff || state_ff == cpuit_pkg::ST_IDLE;
    nxt_done = 1'b0;
    nxt_info = info_ff;
    unique case (state_ff)
      cpuit_pkg::ST_IDLE: begin
        if (accept) begin
          nxt_info = dec;
          // RULE_03 count cycles on zero wait memory
          if (dec.cycles == `CPUIT_CYC_1) begin
            nxt_done = 1'b1;
          end else begin
            nxt_state = cpuit_pkg::ST_EXEC;
            nxt_cnt = dec.cycles - 5'h01;
            nxt_ready = 1'b0;
          end
        end
      end
      cpuit_pkg::ST_EXEC: begin
        nxt_cnt = cnt_ff - 5'h01;
        if (cnt_ff == `CPUIT_CYC_1) begin
          nxt_done = 1'b1;
          nxt_ready = 1'b1;
          nxt_state = cpuit_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_state = cpuit_pkg::ST_IDLE;
        nxt_ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstSyncN_ff) begin
    if (!rstSyncN_ff) begin
      state_ff <= cpuit_pkg::ST_IDLE;
      cnt_ff <= 5'h00;
      ready_ff <= 1'b0;
      done_ff <= 1'b0;
      info_ff <= '0;
    end else if (ce) begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      ready_ff <= nxt_ready;
      done_ff <= nxt_done;
      info_ff <= nxt_info;
    end
  end

  assign instReady = ready_ff;
  assign instDone = done_ff;
  assign decInfo = info_ff;

  sequence s_two;
    accept && dec.cycles == 5'h02 ##1 (ce && !done_ff);
  endsequence

  sequence s_three;
    accept && dec.cycles == 5'h03 ##1 (ce && !ready_ff) [*2];
  endsequence

  property p_two_done;
    @(posedge clk) disable iff (!rstSyncN_ff)
      s_two |=> done_ff && ready_ff;
  endproperty
  a_two_done: assert property (p_two_done) // RULE_03
    else $error("two-cycle op did not finish on time");

  property p_three_done;
    @(posedge clk) disable iff (!rstSyncN_ff)
      s_three |=> done_ff && ready_ff;
  endproperty
  a_three_done: assert property (p_three_done) // RULE_15
    else $error("three-cycle op did not finish on time");

  property p_cmpbr_undef;
    @(posedge clk) disable iff (!rstSyncN_ff)
      accept && instLo[15:12] == 4'hB && !instLo[10] && instLo[8]
        |=> info_ff.undef && done_ff;
  endproperty
  a_cmpbr_undef: assert property (p_cmpbr_undef) // RULE_16
    else $error("compare-and-branch not undefined");

  property p_blink;
    @(posedge clk) disable iff (!rstSyncN_ff)
      accept && instLo[15:11] == 5'h1E && instHi[15:14] == 2'h3 &&
        instHi[12] |=> info_ff.wide && info_ff.cycles == 5'h03;
  endproperty
  a_blink: assert property (p_blink) // RULE_02
    else $error("linked branch not three cycles");

  property p_mem;
    @(posedge clk) disable iff (!rstSyncN_ff)
      accept && instLo[15:12] == 4'h6
        |=> info_ff.cycles == ($past(ioTarget) ? 5'h01 : 5'h02);
  endproperty
  a_mem: assert property (p_mem) // RULE_08
    else $error("single access cycle count wrong");

  property p_cond;
    @(posedge clk) disable iff (!rstSyncN_ff)
      accept && instLo[15:12] == 4'hD && instLo[11:9] != 3'h7
        |=> info_ff.cycles == ($past(condTaken) ? 5'h02 : 5'h01);
  endproperty
  a_cond: assert property (p_cond) // RULE_11
    else $error("conditional branch cycle count wrong");

  property p_shift;
    @(posedge clk) disable iff (!rstSyncN_ff)
      accept && instLo[15:13] == 3'h0 && instLo[12:11] != 2'h3
        |=> done_ff && info_ff.cycles == 5'h01;
  endproperty
  a_shift: assert property (p_shift) // RULE_04
    else $error("shift not single cycle");

  property p_poppc;
    @(posedge clk) disable iff (!rstSyncN_ff)
      accept && instLo[15:8] == 8'hBD
        |=> info_ff.cycles == 5'h04 + 5'($countones($past(instLo[7:0])));
  endproperty
  a_poppc: assert property (p_poppc) // RULE_10
    else $error("pop with PC cycle count wrong");

  property p_brx;
    @(posedge clk) disable iff (!rstSyncN_ff)
      accept && instLo[15:8] == 8'h47 |=> info_ff.cycles == 5'h02;
  endproperty
  a_brx: assert property (p_brx) // RULE_12
    else $error("register branch not two cycles");

  property p_wait;
    @(posedge clk) disable iff (!rstSyncN_ff)
      accept && instLo[15:5] == 11'h5F9 && instLo[3:0] == 4'h0
        |=> info_ff.cycles == 5'h02 && !done_ff;
  endproperty
  a_wait: assert property (p_wait) // RULE_13
    else $error("wait hint not two cycles");

endmodule

// file: include/cpuit_params.svh
// Encoding patterns and cycle counts for the instruction timing decoder
`ifndef CPUIT_PARAMS_SVH
`define CPUIT_PARAMS_SVH

// Cycle counts
`define CPUIT_CYC_1 5'h01
`define CPUIT_CYC_2 5'h02
`define CPUIT_CYC_3 5'h03
`define CPUIT_POPPC_BASE 5'h03
`define CPUIT_MULTI_BASE 5'h01

// Top five bits of the first halfword
`define CPUIT_W32_A 5'h1D
`define CPUIT_W32_B 5'h1E
`define CPUIT_W32_C 5'h1F
`define CPUIT_OP5_LIT 5'h09
`define CPUIT_OP5_BRU 5'h1C

// Top three, four or six bits of the first halfword
`define CPUIT_OP6_HIREG 6'h11
`define CPUIT_OP4_LSREG 4'h5
`define CPUIT_OP3_LSIMM 3'h3
`define CPUIT_OP4_LSH 4'h8
`define CPUIT_OP4_LSSP 4'h9
`define CPUIT_OP4_MULTI 4'hC
`define CPUIT_OP4_MISC 4'hB
`define CPUIT_OP4_COND 4'hD

// Miscellaneous group, fields within bits 11 to 5
`define CPUIT_MISC_SP 4'h0
`define CPUIT_MISC_EXT 4'h2
`define CPUIT_MISC_REV 4'hA
`define CPUIT_MISC_BREAK 4'hE
`define CPUIT_MISC_HINT 4'hF
`define CPUIT_MISC_CPS 7'h33
`define CPUIT_REV_BAD 2'h2
`define CPUIT_PUSHPOP 2'h2

// Hint codes, bits 7 to 4
`define CPUIT_HINT_EVWAIT 4'h2
`define CPUIT_HINT_IRQWAIT 4'h3

// Condition codes
`define CPUIT_COND_UDF 4'hE
`define CPUIT_COND_SUPCALL 4'hF

// High register operations and wide encodings
`define CPUIT_HIREG_BRX 2'h3
`define CPUIT_HIREG_CMP 2'h1
`define CPUIT_REG_PC 4'hF
`define CPUIT_BLINK_HI 2'h3
`define CPUIT_BAR_LO 16'hF3BF
`define CPUIT_BAR_HI 8'h8F
`define CPUIT_BAR_MIN 4'h4
`define CPUIT_BAR_MAX 4'h6
`define CPUIT_SPECRD_LO 12'hF3E
`define CPUIT_SPECWR_LO 12'hF38
`define CPUIT_SPEC_HI 2'h2

`endif

// file: include/cpuit_pkg.sv
// Types shared by the instruction timing decoder
package cpuit_pkg;

  typedef enum logic [2:0] {
    CL_ALU = 3'h0,
    CL_MEM = 3'h1,
    CL_MULTI = 3'h2,
    CL_BRANCH = 3'h3,
    CL_HINT = 3'h4,
    CL_SYS = 3'h5,
    CL_TRAP = 3'h6,
    CL_UNDEF = 3'h7
  } cpuit_class_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } cpuit_state_t;

  typedef struct packed {
    cpuit_class_t cls;
    logic [4:0] cycles;
    logic undef;
    logic wide;
  } cpuit_dec_t;

endpackage

// file: bench/cpuit_mem_model.sv
// Far-side model that routes each data access to the port or the bus
`timescale 1ns/1ns

module cpuit_mem_model (
  // Access address
  input wire logic [31:0] addr,
  // Target select
  output logic ioTarget
);
  always_comb begin
    ioTarget = (addr[31:28] == 4'hD);
  end
endmodule

// file: bench/cpu_instruction_timing_tb_top.sv
// Self-checking bench for the instruction timing decoder
`timescale 1ns/1ns

module cpu_instruction_timing_tb_top;
  logic clk;
  logic resetn;
  logic ce;
  logic instValid;
  logic [15:0] instLo;
  logic [15:0] instHi;
  logic [31:0] accAddr;
  logic ioTarget;
  logic condTaken;
  logic instReady;
  logic instDone;
  cpuit_pkg::cpuit_dec_t decInfo;
  cpuit_pkg::cpuit_dec_t held;
  int fails;
  int cmp_count;
  int seed;
  int i;
  logic [15:0] r;
  logic [7:0] lst;
  logic [15:0] aluOps [19] = '{16'h0123, 16'h0845, 16'h1089, 16'h4080,
    16'h40C0, 16'h4100, 16'h41C0, 16'hB200, 16'hB240, 16'hB280, 16'hB2C0,
    16'hBA00, 16'hBA40, 16'hBAC0, 16'hB004, 16'hB084, 16'hA804, 16'hA004,
    16'h4587};
  logic [15:0] memOps [17] = '{16'h6800, 16'h6000, 16'h7800, 16'h7000,
    16'h8800, 16'h8000, 16'h5000, 16'h5200, 16'h5400, 16'h5600, 16'h5800,
    16'h5A00, 16'h5C00, 16'h5E00, 16'h4800, 16'h9800, 16'h9000};

  cpuit_decoder #(
    .SUPCALL_CYCLES(5'h06),
    .BREAK_CYCLES(5'h07)
  ) i_cpuit_decoder (
    .clk(clk), .resetn(resetn), .ce(ce),
    .instValid(instValid), .instLo(instLo), .instHi(instHi),
    .ioTarget(ioTarget), .condTaken(condTaken),
    .instReady(instReady), .instDone(instDone), .decInfo(decInfo)
  );

  cpuit_mem_model i_cpuit_mem_model (
    .addr(accAddr),
    .ioTarget(ioTarget)
  );

  always #10 clk = ~clk;

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
                     input string what);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  function automatic int ones8(input logic [7:0] v);
    int n;
    n = 0;
    for (int k = 0; k < 8; k++) begin
      n += int'(v[k]);
    end
    return n;
  endfunction

  // Issue one instruction, count cycles to completion, check the decode
  task automatic t(input logic [15:0] lo, input logic [15:0] hi,
                   input bit io, input bit tk, input int cyc, input int cls);
    int n;
    cpuit_pkg::cpuit_dec_t got;
    n = 0;
    instLo = lo;
    instHi = hi;
    condTaken = tk;
    accAddr = {(io ? 4'hD : 4'h2), 28'($random(seed))};
    instValid = 1'b1;
    while (instReady !== 1'b1) begin
      n++;
      if (n > 40) begin
        fails++;
        close_out();
      end
      @(negedge clk);
    end
    @(negedge clk);
    got = decInfo;
    n = 1;
    while (instDone !== 1'b1 && n < 40) begin
      chk(16'(instReady), 16'h0000, "ready while busy");
      instLo = 16'($random(seed));
      condTaken = ~tk;
      @(negedge clk);
      n++;
    end
    if (instDone !== 1'b1) begin
      fails++;
      close_out();
    end
    chk(16'(instReady), 16'h0001, "ready at done");
    chk(16'(n), 16'(cyc), "cycles to done");
    chk(16'(got.cycles), 16'(cyc), "reported cycles");
    chk(16'(decInfo), 16'(got), "info held");
    if (cls < 8) begin
      chk(16'(got.cls), 16'(cls), "class");
      chk(16'(got.undef), 16'(cls == 7), "undef flag");
    end
    if (cls < 7) begin
      chk(16'(got.wide), 16'(lo[15:11] > 5'h1C), "wide flag");
    end
  endtask

  initial begin
    seed = 59223;
    clk = 1'b0;
    resetn = 1'b0;
    ce = 1'b1;
    instValid = 1'b0;
    instLo = 16'h0000;
    instHi = 16'h0000;
    accAddr = 32'h0000_0000;
    condTaken = 1'b0;
    fails = 0;
    cmp_count = 0;
    repeat (10) @(negedge clk);
    chk(16'({instReady, instDone}), 16'h0000, "outputs in reset");
    chk(16'(decInfo), 16'h0000, "info in reset");
    resetn = 1'b1;
    foreach (aluOps[k]) t(aluOps[k], 16'h0000, 0, 0, 1, 0);
    t(16'h4600, 16'h0000, 1, 1, 1, 0);
    for (i = 0; i < 34; i++) begin
      t(memOps[i % 17], 16'h0000, i > 16, 0, (i > 16) ? 1 : 2, 1);
    end
    t(16'hC8FF, 16'h0000, 1, 0, 9, 2);
    t(16'hC001, 16'h0000, 0, 0, 2, 2);
    t(16'hB401, 16'h0000, 0, 0, 2, 2);
    t(16'hBC80, 16'h0000, 1, 0, 2, 2);
    t(16'hB500, 16'h0000, 0, 0, 2, 2);
    t(16'hBD00, 16'h0000, 0, 0, 4, 2);
    t(16'hBDFF, 16'h0000, 0, 0, 12, 2);
    for (i = 0; i < 28; i++) begin
      t({4'hD, 4'(i / 2), 8'h10}, 16'h0000, 0, i % 2, 1 + i % 2, 3);
    end
    t(16'h4708, 16'h0000, 0, 0, 2, 3);
    t(16'h4788, 16'h0000, 0, 0, 2, 3);
    t(16'hBF20, 16'h0000, 0, 0, 2, 4);
    t(16'hBF30, 16'h0000, 0, 0, 2, 4);
    t(16'hBF10, 16'h0000, 0, 0, 1, 4);
    t(16'hBF40, 16'h0000, 0, 0, 1, 4);
    t(16'hDF05, 16'h0000, 0, 0, 6, 6);
    t(16'hBE01, 16'h0000, 0, 0, 7, 6);
    t(16'h4687, 16'h0000, 0, 0, 2, 3);
    t(16'h4487, 16'h0000, 0, 0, 2, 3);
    t(16'hE000, 16'h0000, 0, 0, 2, 3);
    t(16'hF000, 16'hD000, 0, 0, 3, 3);
    t(16'hF3BF, 16'h8F5F, 0, 0, 3, 5);
    t(16'hF3BF, 16'h8F4F, 0, 0, 3, 5);
    t(16'hF3BF, 16'h8F6F, 0, 0, 3, 5);
    t(16'hF3EF, 16'h8000, 0, 0, 3, 5);
    t(16'hF380, 16'h8800, 0, 0, 3, 5);
    t(16'hB100, 16'h0000, 0, 0, 1, 7);
    t(16'hB900, 16'h0000, 0, 0, 1, 7);
    t(16'hBF08, 16'h0000, 0, 0, 1, 7);
    t(16'hDE00, 16'h0000, 0, 0, 1, 7);
    t(16'hE800, 16'h0000, 0, 0, 1, 7);
    t(16'hF000, 16'h0000, 0, 0, 1, 7);
    for (i = 0; i < 80; i++) begin
      r = 16'($random(seed));
      lst = r[7:0] | 8'h01;
      case (i % 4)
        0: t({3'b000, r[12:0]}, r, r[13], r[0], 1, 0);
        1: t({4'h5, r[11:0]}, 16'h0000, r[3], 0, r[3] ? 1 : 2, 1);
        2: t({5'h19, r[10:8], lst}, 16'h0000, r[9], 0, 1 + ones8(lst), 2);
        default: t({4'hD, 4'(r[11:8] % 14), r[7:0]}, 16'h0000, 0, r[14],
                   r[14] ? 2 : 1, 3);
      endcase
    end
    // Clock enable low: a request must not be taken
    instValid = 1'b0;
    @(negedge clk);
    held = decInfo;
    ce = 1'b0;
    instValid = 1'b1;
    instLo = 16'hE000;
    repeat (3) @(negedge clk);
    chk(16'(instDone), 16'h0000, "done with enable low");
    chk(16'(decInfo), 16'(held), "info with enable low");
    chk(16'(instReady), 16'h0001, "ready with enable low");
    ce = 1'b1;
    instValid = 1'b0;
    @(negedge clk);
    resetn = 1'b0;
    @(negedge clk);
    chk(16'(decInfo), 16'h0000, "info in second reset");
    resetn = 1'b1;
    t(16'hBDFF, 16'h0000, 0, 0, 12, 2);
    instValid = 1'b0;
    close_out();
  end
endmodule
